// ==== inc/ebd_pkg.sv ====
// constants, field layout and carrier types for the external bank decoder
package ebd_pkg;
    localparam int EBD_BANKS = 4;
    // register byte addresses and reset value
    localparam logic [31:0] EBD_BANK0_CTRL_ADDR = 32'hFFF0_1018;
    localparam logic [31:0] EBD_BANK1_CTRL_ADDR = 32'hFFF0_101C;
    localparam logic [31:0] EBD_BANK2_CTRL_ADDR = 32'hFFF0_1020;
    localparam logic [31:0] EBD_BANK3_CTRL_ADDR = 32'hFFF0_1024;
    localparam logic [31:0] EBD_CTRL_RESET = 32'h0000_0000;
    // field positions inside a bank control word
    localparam int EBD_BASE_MSB = 31;
    localparam int EBD_BASE_LSB = 19;
    localparam int EBD_SIZE_MSB = 18;
    localparam int EBD_SIZE_LSB = 16;
    localparam int EBD_ALIGN_BIT = 15;
    localparam int EBD_ACC_MSB = 14;
    localparam int EBD_ACC_LSB = 11;
    localparam int EBD_HOLD_MSB = 10;
    localparam int EBD_HOLD_LSB = 8;
    localparam int EBD_WIDTH_MSB = 1;
    localparam int EBD_WIDTH_LSB = 0;
    // decode figures
    localparam int EBD_START_SHIFT = 18;
    localparam logic [32:0] EBD_SIZE_MIN_BYTES = 33'h0_0004_0000;
    localparam logic [2:0] EBD_SIZE_MAX_CODE = 3'h5;
    localparam logic [3:0] EBD_ACC_SPLIT = 4'h8;
    localparam logic [1:0] EBD_WIDTH_OFF = 2'h0;
    localparam logic [1:0] EBD_WIDTH_16 = 2'h2;
    localparam logic [1:0] EBD_WIDTH_32 = 2'h3;
    // bus answers
    localparam logic [1:0] EBD_RESP_OKAY = 2'h0;
    localparam logic [1:0] EBD_RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        EBD_IDLE = 4'b0001,
        EBD_STROBE = 4'b0010,
        EBD_HOLD = 4'b0100,
        EBD_DONE = 4'b1000
    } ebd_state_t;

    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic [3:0] byteEn;
    } ebd_req_t;

    typedef struct packed {
        logic [20:0] addr;
        logic [3:0] csN;
        logic writeStrobeN;
        logic [3:0] byteWriteStrobeN;
        logic outputEnableN;
    } ebd_ext_t;

    localparam ebd_ext_t EBD_EXT_IDLE = {21'h0, 4'hF, 1'b1, 4'hF, 1'b1};
endpackage

// ==== rtl/ebd_bank_decoder.sv ====
// four-bank external I/O decoder with strobe timing and AXI4-Lite registers
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module ebd_bank_decoder import ebd_pkg::*; (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic reqValid,
    input wire ebd_req_t reqIn,
    output logic reqDone,
    output logic reqMiss,
    output ebd_ext_t extBus
);
    logic [31:0] ctrl_r [EBD_BANKS];
    logic [31:0] ctrl_nxt [EBD_BANKS];
    logic awHave_r, awHave_nxt, wHave_r, wHave_nxt;
    logic [31:0] awAddr_r, awAddr_nxt, wData_r, wData_nxt;
    logic [3:0] wStrb_r, wStrb_nxt;
    logic awReady_r, awReady_nxt, wReady_r, wReady_nxt;
    logic bValid_r, bValid_nxt, rValid_r, rValid_nxt, arReady_r, arReady_nxt;
    logic [1:0] bResp_r, bResp_nxt, rResp_r, rResp_nxt;
    logic [31:0] rData_r, rData_nxt;
    ebd_state_t state_r, state_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    ebd_ext_t ext_r, ext_nxt;
    logic done_r, done_nxt, miss_r, miss_nxt;
    logic [EBD_BANKS-1:0] bankHit;
    logic [1:0] selBank;
    logic anyHit;

    // map a byte address onto a bank index
    function automatic logic [2:0] regIndex(input logic [31:0] a);
        case (a)
            EBD_BANK0_CTRL_ADDR: regIndex = 3'h4;
            EBD_BANK1_CTRL_ADDR: regIndex = 3'h5;
            EBD_BANK2_CTRL_ADDR: regIndex = 3'h6;
            EBD_BANK3_CTRL_ADDR: regIndex = 3'h7;
            default: regIndex = 3'h0;
        endcase
    endfunction

    // strobe length in clocks; reserved code 0 runs as one clock
    function automatic logic [4:0] accClocks(input logic [3:0] code);
        if (code == 4'h0) begin
            accClocks = 5'h01;
        end else if (code < EBD_ACC_SPLIT) begin
            accClocks = {1'b0, code};
        end else begin
            accClocks = 5'({code, 1'b0} - 5'h07);
        end
    endfunction

    // per-bank window compare
    for (genvar g = 0; g < EBD_BANKS; g++) begin : gBank
        logic [32:0] start, span;
        logic [2:0] sizeCode;
        logic enabled;
        assign sizeCode = ctrl_r[g][EBD_SIZE_MSB:EBD_SIZE_LSB];
        assign start = 33'({ctrl_r[g][EBD_BASE_MSB:EBD_BASE_LSB], 18'h0});
        assign span = EBD_SIZE_MIN_BYTES << sizeCode;
        // zero width disables the bank, unless byte alignment overrides width
        assign enabled = ctrl_r[g][EBD_ALIGN_BIT]
            || (ctrl_r[g][EBD_WIDTH_MSB:EBD_WIDTH_LSB] != EBD_WIDTH_OFF);
        assign bankHit[g] = enabled && (sizeCode <= EBD_SIZE_MAX_CODE)
            && ({1'b0, reqIn.addr} >= start) && ({1'b0, reqIn.addr} < start + span);
    end

    // lowest bank wins when windows overlap
    always_comb begin
        selBank = 2'h0;
        anyHit = 1'b0;
        for (int i = EBD_BANKS - 1; i >= 0; i--) begin
            if (bankHit[i]) begin
                selBank = 2'(i);
                anyHit = 1'b1;
            end
        end
    end

    // register bus next state; write and read each handle one transfer at a time
    always_comb begin
        logic [2:0] wIdx;
        logic [2:0] rIdx;
        wIdx = regIndex(awAddr_r);
        rIdx = regIndex(s_axi_araddr);
        ctrl_nxt = ctrl_r;
        awHave_nxt = awHave_r;
        wHave_nxt = wHave_r;
        awAddr_nxt = awAddr_r;
        wData_nxt = wData_r;
        wStrb_nxt = wStrb_r;
        bValid_nxt = bValid_r;
        bResp_nxt = bResp_r;
        rValid_nxt = rValid_r;
        rResp_nxt = rResp_r;
        rData_nxt = rData_r;
        if (s_axi_awvalid && awReady_r) begin
            awHave_nxt = 1'b1;
            awAddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && wReady_r) begin
            wHave_nxt = 1'b1;
            wData_nxt = s_axi_wdata;
            wStrb_nxt = s_axi_wstrb;
        end
        if (awHave_r && wHave_r && !bValid_r) begin
            bValid_nxt = 1'b1;
            bResp_nxt = wIdx[2] ? EBD_RESP_OKAY : EBD_RESP_SLVERR;
            if (wIdx[2]) begin
                for (int b = 0; b < 4; b++) begin
                    if (wStrb_r[b]) begin
                        ctrl_nxt[wIdx[1:0]][b*8 +: 8] = wData_r[b*8 +: 8];
                    end
                end
            end
        end
        if (bValid_r && s_axi_bready) begin
            bValid_nxt = 1'b0;
            awHave_nxt = 1'b0;
            wHave_nxt = 1'b0;
        end
        if (rValid_r && s_axi_rready) begin
            rValid_nxt = 1'b0;
        end
        if (s_axi_arvalid && arReady_r) begin
            rValid_nxt = 1'b1;
            rResp_nxt = rIdx[2] ? EBD_RESP_OKAY : EBD_RESP_SLVERR;
            rData_nxt = rIdx[2] ? ctrl_r[rIdx[1:0]] : 32'h0000_0000;
        end
        awReady_nxt = !awHave_nxt;
        wReady_nxt = !wHave_nxt;
        arReady_nxt = !rValid_nxt;
    end

    // register bus flops
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            for (int i = 0; i < EBD_BANKS; i++) begin
                ctrl_r[i] <= EBD_CTRL_RESET;
            end
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
            awAddr_r <= 32'h0000_0000;
            wData_r <= 32'h0000_0000;
            wStrb_r <= 4'h0;
            awReady_r <= 1'b0;
            wReady_r <= 1'b0;
            arReady_r <= 1'b0;
            bValid_r <= 1'b0;
            bResp_r <= EBD_RESP_OKAY;
            rValid_r <= 1'b0;
            rResp_r <= EBD_RESP_OKAY;
            rData_r <= 32'h0000_0000;
        end else begin
            ctrl_r <= ctrl_nxt;
            awHave_r <= awHave_nxt;
            wHave_r <= wHave_nxt;
            awAddr_r <= awAddr_nxt;
            wData_r <= wData_nxt;
            wStrb_r <= wStrb_nxt;
            awReady_r <= awReady_nxt;
            wReady_r <= wReady_nxt;
            arReady_r <= arReady_nxt;
            bValid_r <= bValid_nxt;
            bResp_r <= bResp_nxt;
            rValid_r <= rValid_nxt;
            rResp_r <= rResp_nxt;
            rData_r <= rData_nxt;
        end
    end

    // external access sequencer: strobe phase, then chip-select hold
    always_comb begin
        logic [31:0] sel;
        sel = ctrl_r[selBank];
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        ext_nxt = ext_r;
        miss_nxt = miss_r;
        case (state_r)
            EBD_IDLE: begin
                miss_nxt = 1'b0;
                if (reqValid && anyHit) begin
                    state_nxt = EBD_STROBE;
                    cnt_nxt = accClocks(sel[EBD_ACC_MSB:EBD_ACC_LSB]) - 5'h01;
                    ext_nxt.csN = ~(4'h1 << selBank);
                    ext_nxt.writeStrobeN = !reqIn.write;
                    ext_nxt.byteWriteStrobeN = reqIn.write ? ~reqIn.byteEn : 4'hF;
                    ext_nxt.outputEnableN = reqIn.write;
                    if (sel[EBD_ALIGN_BIT]) begin
                        ext_nxt.addr = reqIn.addr[20:0];
                    end else if (sel[EBD_WIDTH_MSB:EBD_WIDTH_LSB] == EBD_WIDTH_32) begin
                        ext_nxt.addr = reqIn.addr[22:2];
                    end else if (sel[EBD_WIDTH_MSB:EBD_WIDTH_LSB] == EBD_WIDTH_16) begin
                        ext_nxt.addr = reqIn.addr[21:1];
                    end else begin
                        ext_nxt.addr = reqIn.addr[20:0];
                    end
                end else if (reqValid) begin
                    state_nxt = EBD_DONE; // no bank claims it
                    miss_nxt = 1'b1;
                end
            end
            EBD_STROBE: begin
                if (cnt_r != 5'h00) begin
                    cnt_nxt = cnt_r - 5'h01;
                end else begin
                    ext_nxt.writeStrobeN = 1'b1;
                    ext_nxt.byteWriteStrobeN = 4'hF;
                    ext_nxt.outputEnableN = 1'b1;
                    cnt_nxt = {2'h0, ctrl_r[selBank][EBD_HOLD_MSB:EBD_HOLD_LSB]};
                    if (cnt_nxt == 5'h00) begin
                        ext_nxt.csN = 4'hF;
                        state_nxt = EBD_DONE;
                    end else begin
                        cnt_nxt = cnt_nxt - 5'h01;
                        state_nxt = EBD_HOLD;
                    end
                end
            end
            EBD_HOLD: begin
                if (cnt_r != 5'h00) begin
                    cnt_nxt = cnt_r - 5'h01;
                end else begin
                    ext_nxt.csN = 4'hF;
                    state_nxt = EBD_DONE;
                end
            end
            EBD_DONE: begin
                state_nxt = EBD_IDLE;
                miss_nxt = 1'b0; // miss lasts exactly as long as the done pulse
            end
            default: begin
                state_nxt = EBD_IDLE;
                ext_nxt = EBD_EXT_IDLE;
            end
        endcase
        done_nxt = (state_nxt == EBD_DONE);
    end

    // sequencer flops; selBank is stable because the requester holds its address
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r <= EBD_IDLE;
            cnt_r <= 5'h00;
            ext_r <= EBD_EXT_IDLE;
            done_r <= 1'b0;
            miss_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            ext_r <= ext_nxt;
            done_r <= done_nxt;
            miss_r <= miss_nxt;
        end
    end

    assign s_axi_awready = awReady_r;
    assign s_axi_wready = wReady_r;
    assign s_axi_bvalid = bValid_r;
    assign s_axi_bresp = bResp_r;
    assign s_axi_arready = arReady_r;
    assign s_axi_rvalid = rValid_r;
    assign s_axi_rresp = rResp_r;
    assign s_axi_rdata = rData_r;
    assign reqDone = done_r;
    assign reqMiss = miss_r;
    assign extBus = ext_r;

    // helper: measure the strobe and remember the length it should have had
    // expected length restated from the access table, not from accClocks, so a slip there shows
    logic [4:0] strobeLen_r, expectLen_r;
    logic [3:0] accCode;
    assign accCode = ctrl_r[selBank][EBD_ACC_MSB:EBD_ACC_LSB];
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            strobeLen_r <= 5'h00;
            expectLen_r <= 5'h00;
        end else begin
            strobeLen_r <= (state_r == EBD_STROBE) ? strobeLen_r + 5'h01 : 5'h00;
            if (state_r == EBD_IDLE) begin
                if (accCode[3]) begin
                    expectLen_r <= 5'h09 + {1'b0, accCode[2:0], 1'b0};
                end else begin
                    expectLen_r <= (accCode == 4'h0) ? 5'h01 : {1'b0, accCode};
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    ctrl_reset_zero_a: assert property ($rose(rst_b) |-> ctrl_r[2] == EBD_CTRL_RESET)
        else $error("bank control not zero after reset");
    access_selects_bank_a: assert property (
        state_r == EBD_IDLE && reqValid && anyHit |=> extBus.csN != 4'hF)
        else $error("hit did not assert a chip select");
    start_address_hit_a: assert property (
        ctrl_r[0][EBD_WIDTH_MSB:EBD_WIDTH_LSB] != 2'h0 && ctrl_r[0][18:16] <= 3'h5
        && reqIn.addr == {1'b0, ctrl_r[0][31:19], 18'h0} |-> bankHit[0])
        else $error("bank start address not decoded");
    window_bound_a: assert property (
        bankHit[1] |-> (reqIn.addr - {1'b0, ctrl_r[1][31:19], 18'h0})
        < (32'h0004_0000 << ctrl_r[1][18:16]))
        else $error("hit outside bank window");
    reserved_size_a: assert property (ctrl_r[3][18:17] == 2'h3 |-> !bankHit[3])
        else $error("reserved size code matched");
    byte_align_addr_a: assert property (
        state_r == EBD_IDLE && reqValid && anyHit && ctrl_r[selBank][15]
        |=> extBus.addr == $past(reqIn.addr[20:0]))
        else $error("aligned address not passed through");
    strobe_length_a: assert property (
        state_r == EBD_STROBE && state_nxt != EBD_STROBE |-> strobeLen_r + 5'h01 == expectLen_r)
        else $error("strobe length differs from access count");
endmodule

// ==== bench/ebd_ext_periph.sv ====
// passive peripheral model that times chip select and strobes on the external bus
`timescale 1ns/10ps
module ebd_ext_periph import ebd_pkg::*; (
    input wire logic clk,
    input wire ebd_ext_t extBus,
    output logic [7:0] stbLen,
    output logic [7:0] csLen,
    output logic [20:0] seenAddr,
    output logic [3:0] seenCsN,
    output logic [3:0] seenByteWeN,
    output logic seenWrite
);
    logic [7:0] stbCnt = 8'h0;
    logic [7:0] csCnt = 8'h0;
    // count select and strobe cycles; results land when select drops, no reset needed
    always @(posedge clk) begin
        if (extBus.csN != 4'hF) begin
            if (csCnt == 8'h0) begin
                seenAddr <= extBus.addr;
                seenCsN <= extBus.csN;
                seenByteWeN <= extBus.byteWriteStrobeN;
                seenWrite <= !extBus.writeStrobeN;
            end
            csCnt <= csCnt + 8'h1;
            if (!extBus.writeStrobeN || !extBus.outputEnableN) stbCnt <= stbCnt + 8'h1;
        end else if (csCnt != 8'h0) begin
            csLen <= csCnt;
            stbLen <= stbCnt;
            csCnt <= 8'h0;
            stbCnt <= 8'h0;
        end
    end
endmodule

// ==== bench/external_io_bank_decoder_tb_top.sv ====
// self-checking bench for the external bank decoder
`timescale 1ns/10ps
module external_io_bank_decoder_tb_top import ebd_pkg::*; ;
    logic clk = 1'b0;
    logic rstB = 1'b0;
    logic [31:0] awaddr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] araddr = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic [3:0] wstrb = 4'hF;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic reqValid = 1'b0;
    ebd_req_t reqIn = '0;
    logic awready, wready, bvalid, arready, rvalid, reqDone, reqMiss, seenWrite;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    ebd_ext_t extBus;
    logic [7:0] stbLen, csLen;
    logic [20:0] seenAddr;
    logic [3:0] seenCsN, seenByteWeN;
    int fail_count = 0;
    int check_count = 0;

    // write lanes follow wstrb so that a partial write can be tried
    ebd_bank_decoder dut (.clk(clk), .rst_b(rstB), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .reqValid(reqValid), .reqIn(reqIn), .reqDone(reqDone),
        .reqMiss(reqMiss), .extBus(extBus));
    ebd_ext_periph periph (.clk(clk), .extBus(extBus), .stbLen(stbLen), .csLen(csLen),
        .seenAddr(seenAddr), .seenCsN(seenCsN), .seenByteWeN(seenByteWeN),
        .seenWrite(seenWrite));

    // 100 ns period
    initial begin
        forever #50 clk = ~clk;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic stall_out();
        fail_count++;
        $display("[FAIL] %0t no answer", $time);
        finish_test();
    endtask

    // strobe length from the access code: 1..7 direct, 8..15 odd steps, 0 runs as one
    function automatic int accN(input int c);
        return (c == 0) ? 1 : ((c < 8) ? c : 2 * c - 7);
    endfunction

    function automatic logic [31:0] ctl(input logic [12:0] f, input logic [2:0] s,
            input logic al, input logic [3:0] ac, input logic [2:0] h, input logic [1:0] wd);
        return {f, s, al, ac, h, 6'h00, wd};
    endfunction

    // address and data offered together, each released when taken
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic awOpen;
        logic wOpen;
        awOpen = 1'b1;
        wOpen = 1'b1;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(posedge clk);
            if (awOpen && awready) begin
                awOpen = 1'b0;
                awvalid <= 1'b0;
            end
            if (wOpen && wready) begin
                wOpen = 1'b0;
                wvalid <= 1'b0;
            end
            if (!awOpen && !wOpen && bvalid) begin
                chk(32'(bresp), 32'(er), "bresp");
                bready <= 1'b0;
                return;
            end
        end
        stall_out();
    endtask

    task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                chk(rdata, ed, "rdata");
                chk(32'(rresp), 32'(er), "rresp");
                rready <= 1'b0;
                return;
            end
        end
        stall_out();
    endtask

    // one system access, checked against the peripheral's view of the wire
    task automatic acc(input logic [31:0] a, input logic w, input logic miss, input int n,
            input int h, input logic [20:0] ea, input logic [3:0] cs);
        @(posedge clk);
        reqIn <= '{addr: a, write: w, byteEn: 4'h5};
        reqValid <= 1'b1;
        for (int k = 1; k < 60; k++) begin
            @(posedge clk);
            if (reqDone) begin
                reqValid <= 1'b0;
                chk(32'(reqMiss), 32'(miss), "miss");
                chk(32'(k), miss ? 32'h2 : 32'(2 + n + h), "done edge");
                if (!miss) begin
                    @(posedge clk);
                    chk(32'(stbLen), 32'(n), "strobe len");
                    chk(32'(csLen), 32'(n + h), "select len");
                    chk(32'(seenAddr), 32'(ea), "ext addr");
                    chk(32'(seenCsN), 32'(cs), "select");
                    chk(32'(seenWrite), 32'(w), "direction");
                    chk(32'(seenByteWeN), w ? 32'hA : 32'hF, "byte strobes");
                end
                return;
            end
        end
        stall_out();
    endtask

    initial begin
        logic [31:0] lim;
        repeat (5) @(posedge clk);
        rstB <= 1'b1;
        for (int b = 0; b < 4; b++) begin
            axi_rd(EBD_BANK0_CTRL_ADDR + 32'(4 * b), EBD_CTRL_RESET, EBD_RESP_OKAY);
        end
        axi_rd(32'hFFF0_1028, 32'h0, EBD_RESP_SLVERR);
        axi_wr(32'hFFF0_1014, 32'hFFFF_FFFF, EBD_RESP_SLVERR);
        for (int b = 0; b < 4; b++) begin
            axi_wr(EBD_BANK0_CTRL_ADDR + 32'(4 * b), 32'hA5C3_0F00 + 32'(b), EBD_RESP_OKAY);
        end
        for (int b = 0; b < 4; b++) begin
            axi_rd(EBD_BANK0_CTRL_ADDR + 32'(4 * b), 32'hA5C3_0F00 + 32'(b), EBD_RESP_OKAY);
        end
        // partial write: only the middle two lanes of bank 2 change
        wstrb <= 4'h6;
        axi_wr(EBD_BANK2_CTRL_ADDR, 32'h1234_5678, EBD_RESP_OKAY);
        wstrb <= 4'hF;
        axi_rd(EBD_BANK2_CTRL_ADDR, 32'hA534_5602, EBD_RESP_OKAY);
        $display("test registers done");
        // bank 0: 32-bit word addressing, window edges
        axi_wr(EBD_BANK0_CTRL_ADDR,
            ctl(13'h0010, 3'h0, 1'b0, 4'h0, 3'h2, 2'h3), EBD_RESP_OKAY);
        acc(32'h0040_1234, 1'b1, 1'b0, 1, 2, 21'(32'h0040_1234 >> 2), 4'hE);
        acc(32'h0040_0000, 1'b0, 1'b0, 1, 2, 21'h10_0000, 4'hE);
        acc(32'h0043_FFFC, 1'b0, 1'b0, 1, 2, 21'(32'h0043_FFFC >> 2), 4'hE);
        acc(32'h0044_0000, 1'b1, 1'b1, 0, 0, 21'h0, 4'hF);
        acc(32'h003F_FFFC, 1'b0, 1'b1, 0, 0, 21'h0, 4'hF);
        // bank 0 again: 8-bit width passes the address unshifted, zero width disables
        axi_wr(EBD_BANK0_CTRL_ADDR,
            ctl(13'h0010, 3'h0, 1'b0, 4'h3, 3'h0, 2'h1), EBD_RESP_OKAY);
        acc(32'h0040_0003, 1'b1, 1'b0, 3, 0, 21'h00_0003, 4'hE);
        axi_wr(EBD_BANK0_CTRL_ADDR,
            ctl(13'h0010, 3'h0, 1'b0, 4'h3, 3'h0, 2'h0), EBD_RESP_OKAY);
        acc(32'h0040_0003, 1'b1, 1'b1, 0, 0, 21'h0, 4'hF);
        // bank 1: byte alignment overrides a disabling width
        axi_wr(EBD_BANK1_CTRL_ADDR,
            ctl(13'h0100, 3'h5, 1'b1, 4'h8, 3'h0, 2'h0), EBD_RESP_OKAY);
        acc(32'h047F_FFFF, 1'b0, 1'b0, accN(8), 0, 21'h1F_FFFF, 4'hD);
        acc(32'h0480_0000, 1'b1, 1'b1, 0, 0, 21'h0, 4'hF);
        $display("test decode done");
        // bank 3: every size code, access and hold count sweep, 16-bit addressing
        for (int s = 0; s < 8; s++) begin
            axi_wr(EBD_BANK3_CTRL_ADDR,
                ctl(13'h1000, 3'(s), 1'b0, 4'(2 * s + 1), 3'(s), 2'h2), EBD_RESP_OKAY);
            lim = 32'h4000_0000 + (32'h0004_0000 << s);
            if (s < 6) begin
                acc(lim - 32'h2, s[0], 1'b0, accN(2 * s + 1), s, 21'((lim - 32'h2) >> 1), 4'h7);
            end
            acc((s < 6) ? lim : 32'h4000_0000, 1'b1, 1'b1, 0, 0, 21'h0, 4'hF);
        end
        $display("test sizes and timing done");
        // reset in mid-run must clear every bank again
        rstB <= 1'b0;
        repeat (3) @(posedge clk);
        rstB <= 1'b1;
        for (int b = 0; b < 4; b++) begin
            axi_rd(EBD_BANK0_CTRL_ADDR + 32'(4 * b), EBD_CTRL_RESET, EBD_RESP_OKAY);
        end
        $display("test reset done");
        finish_test();
    end
endmodule
